// ### rtl/opaddr_pkg.sv
package opaddr_pkg;

   // Widths
   localparam int PC_W = 13;
   localparam int DA_W = 16;

   // Opcode classes, instruction bits 15..12
   localparam logic [3:0] OP_ALU_PAIR               = 4'h0;
   localparam logic [3:0] OP_ALU_SINGLE             = 4'h1;
   localparam logic [3:0] OP_IO_DIRECT              = 4'h2;
   localparam logic [3:0] OP_DATA_DIRECT            = 4'h3;
   localparam logic [3:0] OP_DISP_Y                 = 4'h4;
   localparam logic [3:0] OP_DISP_Z                 = 4'h5;
   localparam logic [3:0] OP_INDIRECT               = 4'h6;
   localparam logic [3:0] OP_PROGRAM_CONSTANT_LOAD  = 4'h7;
   localparam logic [3:0] OP_POINTER_JUMP           = 4'h8;
   localparam logic [3:0] OP_RELATIVE_JUMP          = 4'h9;
   localparam logic [3:0] OP_RELATIVE_CALL          = 4'ha;
   localparam logic [3:0] OP_ABSOLUTE_JUMP          = 4'hb;

   // Field positions
   localparam int OP_MSB    = 15;
   localparam int OP_LSB    = 12;
   localparam int DST_MSB   = 8;
   localparam int DST_LSB   = 4;
   localparam int STORE_BIT = 9;
   localparam int IO_OUT_BIT = 11;
   localparam int CALL_BIT  = 0;

   // Pointer selects and indirect modes
   localparam logic [1:0] PTR_X    = 2'h0;
   localparam logic [1:0] PTR_Y    = 2'h1;
   localparam logic [1:0] PTR_Z    = 2'h2;
   localparam logic [1:0] PM_PLAIN = 2'h0;
   localparam logic [1:0] PM_POST  = 2'h1;
   localparam logic [1:0] PM_PRE   = 2'h2;

   // First register of the pointer pairs
   localparam logic [4:0] PTR_BASE = 5'h1a;

   // Data space layout
   localparam logic [15:0] IO_BASE = 16'h0020;
   localparam logic [15:0] IO_TOP  = 16'h0060;

   // Steps and reset values
   localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
   localparam logic [PC_W-1:0] PC_RST  = 13'h0000;
   localparam logic [15:0]     PTR_STEP = 16'h0001;

   typedef enum logic {st_exec, st_mem2} ex_state_t;
   typedef enum logic [1:0] {sp_reg, sp_io, sp_mem, sp_const} space_t;

endpackage

// ### rtl/rf_if.sv
`timescale 1ns/1ps
interface rf_if;
   logic [4:0]  ra_addr;
   logic [4:0]  rb_addr;
   logic [1:0]  rp_sel;
   logic [7:0]  ra_data;
   logic [7:0]  rb_data;
   logic [15:0] rp_data;
   logic        wa_en;
   logic [4:0]  wa_addr;
   logic [7:0]  wa_data;
   logic        wp_en;
   logic [1:0]  wp_sel;
   logic [15:0] wp_data;

   modport core (output ra_addr, rb_addr, rp_sel, wa_en, wa_addr, wa_data,
                 output wp_en, wp_sel, wp_data,
                 input  ra_data, rb_data, rp_data);
   modport store (input  ra_addr, rb_addr, rp_sel, wa_en, wa_addr, wa_data,
                  input  wp_en, wp_sel, wp_data,
                  output ra_data, rb_data, rp_data);
endinterface

// ### rtl/gpr_store.sv
`timescale 1ns/1ps
module gpr_store (
   // Clock
   input wire logic core_clk,
   // Core side
   rf_if.store      rf
);
   import opaddr_pkg::*;

   logic [7:0]  regs_ff [32];
   logic [7:0]  nxt_regs [32];
   logic [7:0]  ra_ff;
   logic [7:0]  nxt_ra;
   logic [7:0]  rb_ff;
   logic [7:0]  nxt_rb;
   logic [15:0] rp_ff;
   logic [15:0] nxt_rp;
   logic [4:0]  wp_lo;
   logic [4:0]  rp_lo;

   assign wp_lo = PTR_BASE + {2'b00, rf.wp_sel, 1'b0};
   assign rp_lo = PTR_BASE + {2'b00, rf.rp_sel, 1'b0};

   // Write-first: reads see this cycle's writes, so no forwarding elsewhere
   always_comb begin
      nxt_regs = regs_ff;
      if (rf.wa_en) begin
         nxt_regs[rf.wa_addr] = rf.wa_data;
      end
      if (rf.wp_en) begin
         nxt_regs[wp_lo] = rf.wp_data[7:0];
         nxt_regs[5'(wp_lo + 5'h01)] = rf.wp_data[15:8];
      end
      nxt_ra = nxt_regs[rf.ra_addr];
      nxt_rb = nxt_regs[rf.rb_addr];
      nxt_rp = {nxt_regs[5'(rp_lo + 5'h01)], nxt_regs[rp_lo]};
   end

   always_ff @(posedge core_clk) begin
      regs_ff <= nxt_regs;
      ra_ff   <= nxt_ra;
      rb_ff   <= nxt_rb;
      rp_ff   <= nxt_rp;
   end

   assign rf.ra_data = ra_ff;
   assign rf.rb_data = rb_ff;
   assign rf.rp_data = rp_ff;

endmodule

// ### rtl/operand_address_generation.sv
`timescale 1ns/1ps
// What this block does
// - Single-register operations take their operand from the destination field.
// - Pair operations read source and destination, result goes to destination.
// - I/O direct takes a 6-bit address field plus a register field.
// - Data direct uses the whole second instruction word as address.
// - Displacement mode adds a 6-bit field to the Y or Z pointer.
// - Plain indirect uses the X, Y or Z pointer unchanged.
// - Pre-decrement lowers the pointer first and uses the lowered value.
// - Post-increment uses the old pointer, then raises the pointer.
// - Constant load: Z bits 15..1 pick the word, bit 0 the byte.
// - Pointer jump and call load the counter from Z.
// - Relative jump and call go to counter plus offset plus one.
// - Absolute jump and call go to the address in the second word.
// - The core runs straight from the system clock, undivided.
// - Fetch overlaps execution for about one instruction per clock.
// - A register pair operation with write-back finishes in one clock.
// - Every data space access spans two clocks.
// - X, Y and Z are register pairs 26..31.
// - Registers appear at data addresses 0x00 to 0x1f.
// - I/O registers appear at data addresses 0x20 to 0x5f.
module operand_address_generation (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst_b,
   // Program fetch
   output logic [opaddr_pkg::PC_W-1:0]  prog_addr,
   input  wire logic [15:0]             prog_data,
   // Data memory
   output logic [opaddr_pkg::DA_W-1:0]  dmem_addr,
   output logic [7:0]                   dmem_wdata,
   output logic                         dmem_we,
   output logic                         dmem_re,
   input  wire logic [7:0]              dmem_rdata,
   // I/O space
   output logic [5:0]                   io_addr,
   output logic [7:0]                   io_wdata,
   output logic                         io_we,
   output logic                         io_re,
   input  wire logic [7:0]              io_rdata,
   // Program constants
   output logic [14:0]                  const_addr,
   input  wire logic [15:0]             const_data,
   // Return address for the stack unit
   output logic                         call_push,
   output logic [opaddr_pkg::PC_W-1:0]  ret_addr
);
   import opaddr_pkg::*;

   ex_state_t         state_ff, nxt_state;
   logic [PC_W-1:0]   pc_ff, nxt_pc, fpc_ff, nxt_fpc, irpc_ff, nxt_irpc;
   logic [15:0]       ir_ff, nxt_ir;
   logic              irv_ff, nxt_irv, sq_ff, nxt_sq, skip_ff, nxt_skip;
   logic              acc_ld_ff, nxt_acc_ld, byte_ff, nxt_byte;
   space_t            acc_sp_ff, nxt_acc_sp;
   logic [4:0]        acc_d_ff, nxt_acc_d;
   logic [15:0]       daddr_ff, nxt_daddr;
   logic [7:0]        wdata_ff, nxt_wdata;
   logic              dwe_ff, nxt_dwe, dre_ff, nxt_dre;
   logic [5:0]        ioa_ff, nxt_ioa;
   logic              iowe_ff, nxt_iowe, iore_ff, nxt_iore;
   logic [14:0]       caddr_ff, nxt_caddr;
   logic              call_ff, nxt_call;
   logic [PC_W-1:0]   ret_ff, nxt_ret;

   logic [3:0]        op;
   logic [4:0]        dst;
   logic [4:0]        source_operand_reg;
   logic [5:0]        disp;
   logic [5:0]        io_field;
   logic [1:0]        pmode;
   logic [PC_W-1:0]   kx;
   logic              exec;
   logic              access, ld, jump, is_call;
   space_t            sp;
   logic [15:0]       eff;
   logic [PC_W-1:0]   target;
   logic [7:0]        ld_data;

   rf_if rf ();

   gpr_store u_store (
      .core_clk (core_clk),
      .rf       (rf)
   );

   function automatic logic [1:0] ptr_of(input logic [15:0] w);
      logic [1:0] s;
      s = PTR_Z;
      if (w[OP_MSB:OP_LSB] == OP_DISP_Y) begin
         s = PTR_Y;
      end else if (w[OP_MSB:OP_LSB] == OP_INDIRECT) begin
         s = w[3:2];
      end
      return s;
   endfunction

   assign op                 = ir_ff[OP_MSB:OP_LSB];
   assign dst                = ir_ff[DST_MSB:DST_LSB];
   assign source_operand_reg = {ir_ff[9], ir_ff[3:0]};
   assign disp               = {ir_ff[11:10], ir_ff[3:0]};
   assign io_field           = {ir_ff[10:9], ir_ff[3:0]};
   assign pmode              = ir_ff[1:0];
   assign kx                 = {ir_ff[11], ir_ff[11:0]};
   assign exec               = irv_ff && state_ff == st_exec;

   // Operand decode and effective address
   always_comb begin
      access = 1'b0;
      ld     = !ir_ff[STORE_BIT];
      jump   = 1'b0;
      is_call = ir_ff[CALL_BIT];
      eff    = rf.rp_data;
      target = PC_W'(irpc_ff + kx + PC_STEP);
      rf.wp_en   = 1'b0;
      rf.wp_sel  = ptr_of(ir_ff);
      rf.wp_data = rf.rp_data;
      unique case (op)
         OP_IO_DIRECT: begin
            access = 1'b1;
            ld     = !ir_ff[IO_OUT_BIT];
            eff    = IO_BASE + {10'h000, io_field};
         end
         OP_DATA_DIRECT: begin
            access = 1'b1;
            eff    = prog_data;
         end
         OP_DISP_Y, OP_DISP_Z: begin
            access = 1'b1;
            eff    = rf.rp_data + {10'h000, disp};
         end
         OP_INDIRECT: begin
            access = 1'b1;
            if (pmode == PM_POST) begin
               rf.wp_en   = exec;
               rf.wp_data = rf.rp_data + PTR_STEP;
            end else if (pmode == PM_PRE) begin
               eff        = rf.rp_data - PTR_STEP;
               rf.wp_en   = exec;
               rf.wp_data = eff;
            end
         end
         OP_PROGRAM_CONSTANT_LOAD: begin
            access = 1'b1;
            ld     = 1'b1;
         end
         OP_POINTER_JUMP: begin
            jump   = 1'b1;
            target = rf.rp_data[PC_W-1:0];
         end
         OP_RELATIVE_JUMP: begin
            jump    = 1'b1;
            is_call = 1'b0;
         end
         OP_RELATIVE_CALL: begin
            jump    = 1'b1;
            is_call = 1'b1;
         end
         OP_ABSOLUTE_JUMP: begin
            jump   = 1'b1;
            target = prog_data[PC_W-1:0];
         end
         default: begin
         end
      endcase
      if (op == OP_PROGRAM_CONSTANT_LOAD) begin
         sp = sp_const;
      end else if (eff < IO_BASE) begin
         sp = sp_reg;
      end else if (eff < IO_TOP) begin
         sp = sp_io;
      end else begin
         sp = sp_mem;
      end
   end

   // Register file ports; reads are registered, so addresses come early
   always_comb begin
      rf.ra_addr = nxt_ir[DST_MSB:DST_LSB];
      if (exec && access && ld && sp == sp_reg) begin
         rf.ra_addr = eff[4:0];
      end
      rf.rb_addr = {nxt_ir[9], nxt_ir[3:0]};
      rf.rp_sel  = ptr_of(nxt_ir);
   end

   always_comb begin
      unique case (acc_sp_ff)
         sp_reg:   ld_data = rf.ra_data;
         sp_io:    ld_data = io_rdata;
         sp_mem:   ld_data = dmem_rdata;
         sp_const: ld_data = byte_ff ? const_data[15:8]
                                     : const_data[7:0];
      endcase
   end

   // Pipeline and access sequencing
   always_comb begin
      nxt_state = state_ff;
      nxt_pc    = pc_ff + PC_STEP;
      nxt_fpc   = pc_ff;
      nxt_ir    = prog_data;
      nxt_irpc  = fpc_ff;
      nxt_irv   = !sq_ff;
      nxt_sq    = 1'b0;
      nxt_skip  = skip_ff;
      nxt_acc_ld = acc_ld_ff;
      nxt_acc_sp = acc_sp_ff;
      nxt_acc_d  = acc_d_ff;
      nxt_byte   = byte_ff;
      nxt_daddr  = daddr_ff;
      nxt_wdata  = wdata_ff;
      nxt_ioa    = ioa_ff;
      nxt_caddr  = caddr_ff;
      nxt_dwe  = 1'b0;
      nxt_dre  = 1'b0;
      nxt_iowe = 1'b0;
      nxt_iore = 1'b0;
      nxt_call = 1'b0;
      nxt_ret  = ret_ff;
      rf.wa_en   = 1'b0;
      rf.wa_addr = dst;
      rf.wa_data = rf.ra_data;
      unique case (state_ff)
         st_exec: begin
            if (irv_ff && op == OP_ALU_PAIR) begin
               rf.wa_en = 1'b1;
               unique case (ir_ff[11:10])
                  2'h0: rf.wa_data = rf.ra_data + rf.rb_data;
                  2'h1: rf.wa_data = rf.ra_data - rf.rb_data;
                  2'h2: rf.wa_data = rf.ra_data & rf.rb_data;
                  2'h3: rf.wa_data = rf.rb_data;
               endcase
            end else if (irv_ff && op == OP_ALU_SINGLE) begin
               rf.wa_en = 1'b1;
               unique case (ir_ff[11:10])
                  2'h0: rf.wa_data = rf.ra_data + 8'h01;
                  2'h1: rf.wa_data = rf.ra_data - 8'h01;
                  2'h2: rf.wa_data = ~rf.ra_data;
                  2'h3: rf.wa_data = {rf.ra_data[3:0], rf.ra_data[7:4]};
               endcase
            end else if (exec && access) begin
               // Park the next word in ir; it waits out the second clock
               nxt_state  = st_mem2;
               nxt_pc     = pc_ff;
               nxt_fpc    = fpc_ff;
               nxt_skip   = op == OP_DATA_DIRECT;
               nxt_acc_ld = ld;
               nxt_acc_sp = sp;
               nxt_acc_d  = (ld || sp != sp_reg) ? dst : eff[4:0];
               nxt_byte   = rf.rp_data[0];
               nxt_caddr  = rf.rp_data[15:1];
               nxt_daddr  = eff;
               nxt_wdata  = rf.ra_data;
               nxt_ioa    = 6'(eff - IO_BASE);
               nxt_dre    = ld && sp == sp_mem;
               nxt_dwe    = !ld && sp == sp_mem;
               nxt_iore   = ld && sp == sp_io;
               nxt_iowe   = !ld && sp == sp_io;
            end else if (exec && jump) begin
               // Two fetched words behind a jump are dropped
               nxt_pc   = target;
               nxt_irv  = 1'b0;
               nxt_sq   = 1'b1;
               nxt_call = is_call && op != OP_RELATIVE_JUMP;
               nxt_ret  = irpc_ff + PC_STEP +
                          ((op == OP_ABSOLUTE_JUMP) ? PC_STEP : PC_RST);
            end
         end
         st_mem2: begin
            nxt_state  = st_exec;
            nxt_skip   = 1'b0;
            nxt_ir     = ir_ff;
            nxt_irpc   = irpc_ff;
            nxt_irv    = irv_ff && !skip_ff;
            rf.wa_en   = acc_ld_ff || acc_sp_ff == sp_reg;
            rf.wa_addr = acc_d_ff;
            rf.wa_data = acc_ld_ff ? ld_data : wdata_ff;
         end
      endcase
   end

   // All state on the undivided system clock
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= st_exec;
         pc_ff    <= PC_RST;
         fpc_ff   <= PC_RST;
         irpc_ff  <= PC_RST;
         ir_ff    <= 16'h0000;
         irv_ff   <= 1'b0;
         sq_ff    <= 1'b1;
         skip_ff  <= 1'b0;
         acc_ld_ff <= 1'b0;
         acc_sp_ff <= sp_mem;
         acc_d_ff  <= 5'h00;
         byte_ff   <= 1'b0;
         daddr_ff  <= 16'h0000;
         wdata_ff  <= 8'h00;
         dwe_ff    <= 1'b0;
         dre_ff    <= 1'b0;
         ioa_ff    <= 6'h00;
         iowe_ff   <= 1'b0;
         iore_ff   <= 1'b0;
         caddr_ff  <= 15'h0000;
         call_ff   <= 1'b0;
         ret_ff    <= PC_RST;
      end else begin
         state_ff <= nxt_state;
         pc_ff    <= nxt_pc;
         fpc_ff   <= nxt_fpc;
         irpc_ff  <= nxt_irpc;
         ir_ff    <= nxt_ir;
         irv_ff   <= nxt_irv;
         sq_ff    <= nxt_sq;
         skip_ff  <= nxt_skip;
         acc_ld_ff <= nxt_acc_ld;
         acc_sp_ff <= nxt_acc_sp;
         acc_d_ff  <= nxt_acc_d;
         byte_ff   <= nxt_byte;
         daddr_ff  <= nxt_daddr;
         wdata_ff  <= nxt_wdata;
         dwe_ff    <= nxt_dwe;
         dre_ff    <= nxt_dre;
         ioa_ff    <= nxt_ioa;
         iowe_ff   <= nxt_iowe;
         iore_ff   <= nxt_iore;
         caddr_ff  <= nxt_caddr;
         call_ff   <= nxt_call;
         ret_ff    <= nxt_ret;
      end
   end

   assign prog_addr  = pc_ff;
   assign dmem_addr  = daddr_ff;
   assign dmem_wdata = wdata_ff;
   assign dmem_we    = dwe_ff;
   assign dmem_re    = dre_ff;
   assign io_addr    = ioa_ff;
   assign io_wdata   = wdata_ff;
   assign io_we      = iowe_ff;
   assign io_re      = iore_ff;
   assign const_addr = caddr_ff;
   assign call_push  = call_ff;
   assign ret_addr   = ret_ff;

   a_alu_one_clock: assert property (@(posedge core_clk) disable iff (!rst_b)
      exec && op == OP_ALU_PAIR |-> rf.wa_en && rf.wa_addr == dst
         ##1 state_ff == st_exec)
      else $error("pair operation did not write back in one clock");
   a_fetch_overlap: assert property (@(posedge core_clk) disable iff (!rst_b)
      state_ff == st_exec && !(exec && (access || jump))
         |=> pc_ff == PC_W'($past(pc_ff) + PC_STEP))
      else $error("fetch did not advance beside execution");
   a_access_two_clk: assert property (@(posedge core_clk) disable iff (!rst_b)
      exec && access |=> state_ff == st_mem2 && $stable(pc_ff)
         ##1 state_ff == st_exec)
      else $error("data access did not take two clocks");
   a_post_inc_ptr: assert property (@(posedge core_clk) disable iff (!rst_b)
      exec && op == OP_INDIRECT && pmode == PM_POST
         |-> eff == rf.rp_data && rf.wp_en
             && rf.wp_data == 16'(rf.rp_data + PTR_STEP))
      else $error("post-increment address or update wrong");
   a_pre_dec_ptr: assert property (@(posedge core_clk) disable iff (!rst_b)
      exec && op == OP_INDIRECT && pmode == PM_PRE
         |=> daddr_ff == 16'($past(rf.rp_data) - PTR_STEP))
      else $error("pre-decrement address wrong");
   a_disp_sum: assert property (@(posedge core_clk) disable iff (!rst_b)
      exec && (op == OP_DISP_Y || op == OP_DISP_Z)
         |=> daddr_ff == 16'($past(rf.rp_data) + $past(disp)))
      else $error("displacement address wrong");
   a_rel_target: assert property (@(posedge core_clk) disable iff (!rst_b)
      exec && (op == OP_RELATIVE_JUMP || op == OP_RELATIVE_CALL)
         |=> pc_ff == PC_W'($past(irpc_ff) + $past(kx) + PC_STEP)
             && !irv_ff ##1 !irv_ff)
      else $error("relative target wrong or flush missing");
   a_ptr_jump_z: assert property (@(posedge core_clk) disable iff (!rst_b)
      exec && op == OP_POINTER_JUMP
         |=> pc_ff == $past(rf.rp_data[PC_W-1:0]))
      else $error("pointer jump target wrong");
   a_io_window: assert property (@(posedge core_clk) disable iff (!rst_b)
      exec && access && eff >= IO_BASE && eff < IO_TOP && op != OP_PROGRAM_CONSTANT_LOAD
         |=> (io_re || io_we) && !dmem_re && !dmem_we
             && io_addr == 6'($past(eff) - IO_BASE))
      else $error("I/O window mapping wrong");
   a_const_byte: assert property (@(posedge core_clk) disable iff (!rst_b)
      exec && op == OP_PROGRAM_CONSTANT_LOAD
         |=> const_addr == $past(rf.rp_data[15:1])
             && byte_ff == $past(rf.rp_data[0]))
      else $error("constant byte address wrong");

endmodule

// ### verif/mem_model.sv
`timescale 1ns/1ps
module mem_model (
   // Clock
   input  wire logic                         core_clk,
   // Program fetch and constants
   input  wire logic [opaddr_pkg::PC_W-1:0]  prog_addr,
   output logic      [15:0]                  prog_data,
   input  wire logic [14:0]                  const_addr,
   output logic      [15:0]                  const_data,
   // Data and I/O reads
   input  wire logic [15:0]                  dmem_addr,
   input  wire logic                         dmem_re,
   output logic      [7:0]                   dmem_rdata,
   input  wire logic [5:0]                   io_addr,
   input  wire logic                         io_re,
   output logic      [7:0]                   io_rdata
);
   import opaddr_pkg::*;
   logic [15:0] rom [0:8191];
   logic [7:0]  dm [0:65535];
   logic [7:0]  noise = 8'h00;
   initial prog_data = 16'h0000;
   // One clock behind the address, as a synchronous ROM
   always @(posedge core_clk) begin
      prog_data <= rom[prog_addr];
      noise     <= noise + 8'h35;
   end
   // Noise outside the strobe cycle, so a late sample is caught
   assign dmem_rdata = dmem_re ? dm[dmem_addr] : noise;
   assign io_rdata   = io_re ? ~{2'b00, io_addr} : noise;
   assign const_data = rom[const_addr[12:0]];
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
   n_errors++; $display("unexpected %s exp=%h got=%h", nm, ex, got); end end
module testbench;
   import opaddr_pkg::*;
   logic            core_clk = 1'b0;
   logic            rst_b    = 1'b0;
   logic [PC_W-1:0] prog_addr, ret_addr;
   logic [15:0]     prog_data, const_data, dmem_addr;
   logic [14:0]     const_addr;
   logic [7:0]      dmem_wdata, dmem_rdata, io_wdata, io_rdata;
   logic [5:0]      io_addr;
   logic            dmem_we, dmem_re, io_we, io_re, call_push;
   logic [7:0]      r [0:31];
   logic [26:0]     exq [$];
   logic [31:0]     rnd = 32'hfb35;
   int              pc, na, cyc, checks, n_errors;

   always #5 core_clk = ~core_clk;

   operand_address_generation dut (.core_clk(core_clk), .rst_b(rst_b),
      .prog_addr(prog_addr), .prog_data(prog_data), .dmem_addr(dmem_addr),
      .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
      .dmem_rdata(dmem_rdata), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
      .const_addr(const_addr), .const_data(const_data),
      .call_push(call_push), .ret_addr(ret_addr));
   mem_model pm (.core_clk(core_clk), .prog_addr(prog_addr),
      .prog_data(prog_data), .const_addr(const_addr),
      .const_data(const_data), .dmem_addr(dmem_addr), .dmem_re(dmem_re),
      .dmem_rdata(dmem_rdata), .io_addr(io_addr), .io_re(io_re),
      .io_rdata(io_rdata));

   function automatic logic [31:0] nxt();
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      return rnd;
   endfunction
   function automatic logic [15:0] gp(input int p);
      return {r[27+2*p], r[26+2*p]};
   endfunction
   task automatic emit(input logic [15:0] w);
      pm.rom[pc] = w;
      pc++;
   endtask
   // Expected side effect of one access; register space never shows
   task automatic acc(input logic s, input logic [15:0] a, input int d);
      if (a < IO_BASE) begin
         if (s) r[a[4:0]] = r[d];
         else r[d] = r[a[4:0]];
      end else if (a < IO_TOP) begin
         exq.push_back({2'b01, s, 10'h000, 6'(a - IO_BASE),
                        s ? r[d] : 8'h00});
         if (!s) r[d] = ~{2'b00, 6'(a - IO_BASE)};
      end else begin
         exq.push_back({2'b00, s, a, s ? r[d] : 8'h00});
         if (!s) r[d] = pm.dm[a];
      end
   endtask
   task automatic mdir(input logic s, input int d, input logic [15:0] a);
      emit({OP_DATA_DIRECT, 2'b00, s, 5'(d), 4'h0});
      emit(a);
      acc(s, a, d);
   endtask
   task automatic setp(input int p, input logic [15:0] v);
      pm.dm[na] = v[7:0];
      pm.dm[na+1] = v[15:8];
      mdir(0, 26 + 2 * p, 16'(na));
      mdir(0, 27 + 2 * p, 16'(na + 1));
      na += 2;
   endtask
   task automatic ind(input logic s, input int p, input logic [1:0] m,
                      input int d);
      logic [15:0] v;
      v = gp(p) - 16'(m == PM_PRE);
      emit({OP_INDIRECT, 2'b00, s, 5'(d), 2'(p), m});
      {r[27+2*p], r[26+2*p]} = v + 16'(m == PM_POST);
      acc(s, v, d);
   endtask
   task automatic disp(input logic s, input int p, input logic [5:0] q,
                       input int d);
      emit({p == 1 ? OP_DISP_Y : OP_DISP_Z, q[5:4], s, 5'(d), q[3:0]});
      acc(s, gp(p) + 16'(q), d);
   endtask
   task automatic io(input logic s, input logic [5:0] q, input int d);
      emit({OP_IO_DIRECT, s, q[5:4], 5'(d), q[3:0]});
      acc(s, 16'(q) + IO_BASE, d);
   endtask
   task automatic alu(input logic sg, input logic [1:0] f, input int d,
                      input int s);
      logic [7:0] a;
      logic [7:0] b;
      a = r[d];
      b = r[s];
      emit({sg ? OP_ALU_SINGLE : OP_ALU_PAIR, f, s[4], 5'(d), s[3:0]});
      if (sg) a = f == 0 ? a + 1 : f == 1 ? a - 1 : f == 2 ? ~a :
                  {a[3:0], a[7:4]};
      else a = f == 0 ? a + b : f == 1 ? a - b : f == 2 ? a & b : b;
      r[d] = a;
   endtask
   task automatic cld(input int d);
      logic [15:0] z;
      logic [15:0] w;
      z = gp(2);
      w = pm.rom[z[13:1]];
      emit({OP_PROGRAM_CONSTANT_LOAD, 3'b000, 5'(d), 4'h0});
      r[d] = z[0] ? w[15:8] : w[7:0];
   endtask
   task automatic br(input logic [3:0] op, input logic c, input int t);
      if (op == OP_POINTER_JUMP) setp(2, 16'(t));
      if (op == OP_POINTER_JUMP || op == OP_ABSOLUTE_JUMP)
         emit({op, 11'h000, c});
      else emit({op, 12'(t - pc - 1)});
      if (op == OP_ABSOLUTE_JUMP) emit(16'(t));
      if (c) exq.push_back({3'b100, 3'b000, 13'(pc), 8'h00});
      pc = t;
   endtask
   task automatic take(input logic [26:0] g);
      logic [26:0] e;
      e = exq.size() > 0 ? exq.pop_front() : 27'h0;
      `CHK("access", e, g)
   endtask
   task automatic close_out();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         close_out();
      end
      if (rst_b && (dmem_we || dmem_re))
         take({2'b00, dmem_we, dmem_addr, dmem_we ? dmem_wdata : 8'h00});
      if (rst_b && (io_we || io_re))
         take({2'b01, io_we, 10'h000, io_addr, io_we ? io_wdata : 8'h00});
      if (rst_b && call_push)
         take({3'b100, 3'b000, ret_addr, 8'h00});
   end

   initial begin
      logic [31:0] v;
      int          d;
      for (int i = 0; i < 65536; i++) pm.dm[i] = 8'(nxt());
      for (int i = 0; i < 8192; i++)
         pm.rom[i] = i < 4096 ? 16'h2e0f : 16'(nxt());
      // Z table for constant loads, written before any random read
      for (int j = 0; j < 64; j++)
         pm.dm[128+j] = j[0] ? {3'b001, 5'(nxt())} : 8'(nxt());
      pc = 0;
      na = 16'h0060;
      for (int i = 0; i < 32; i++) mdir(0, i, 16'(256 + i));
      setp(0, 16'h0000);
      ind(1, 0, PM_PRE, 5);
      setp(2, 16'hfff0);
      disp(1, 2, 6'h3f, 6);
      setp(1, 16'h0123);
      ind(0, 1, PM_POST, 7);
      ind(1, 1, PM_PLAIN, 7);
      for (int b = 0; b < 2; b++) begin
         setp(2, 16'(16'h2000 + b));
         cld(8);
         mdir(1, 8, 16'hff40);
      end
      br(OP_RELATIVE_JUMP, 0, pc + 2048);
      br(OP_RELATIVE_CALL, 1, pc + 3);
      for (int c = 0; c < 2; c++) begin
         br(OP_POINTER_JUMP, c[0], pc + 30);
         br(OP_ABSOLUTE_JUMP, c[0], pc + 9);
      end
      for (int n = 0; n < 60; n++) begin
         v = nxt();
         d = int'(v[12:8]) % 26;
         case (v[2:0])
            0: ind(v[3], int'(v[5:4]) % 3, 2'(v[7:6] % 3), d);
            1: disp(v[3], 1 + int'(v[4]), v[21:16], d);
            2: io(v[3], v[21:16], d);
            3: alu(v[3], v[5:4], d, int'(v[20:16]));
            4: begin
               mdir(0, 30, 16'(128 + 2 * v[8:4]));
               mdir(0, 31, 16'(129 + 2 * v[8:4]));
               cld(d);
            end
            default: mdir(v[3], d, v[3] ? v[31:16] : 16'(256 + v[31:24]));
         endcase
      end
      for (int i = 0; i < 32; i++) mdir(1, i, 16'(16'hff00 + i));
      emit({OP_RELATIVE_JUMP, 12'hfff});
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 20000 && exq.size() > 0; i++) @(posedge core_clk);
      repeat (20) @(posedge core_clk);
      `CHK("pending", 0, exq.size())
      close_out();
   end
endmodule
